// ---- rtl/dio_pkg.sv ----
// Package with register map, field layouts, timing counts and carrier types of the digital I/O port
// What this block does
// - Twenty-four lines: eight waveform port lines, sixteen programmable-function lines.
// - Software sets the direction of every line independently.
// - Clocked waveform transfer only on the eight-line port, eight-bit samples.
// - Generation FIFO of 2047 samples, regenerate from FIFO or stream from host.
// - Acquisition FIFO of 2047 samples before transfer to the host.
// - Input sample clock from zero up to 10 MHz.
// - Output sample clock from zero up to 10 MHz, both modes.
// - Sample clock selectable from function lines, trigger bus, analog clocks, counters, others.
// - Six DMA channels, each assignable to AI, DI, DO or a counter.
// - Function lines act as static in, static out, timing in or timing out.
// - Timing output lines driven from one of many internal timing signals.
// - Per-function-line debounce of 125 ns, 6.425 us, 2.56 ms or off, both edges; waveform port lines are unfiltered.
package dio_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned FIFO_DEPTH = 2047;
	localparam int unsigned FIFO_AW = 11;
	localparam int unsigned PFI_N = 16;
	localparam int unsigned DMA_N = 6;
	// Debounce times in ns and derived cycle counts
	localparam int unsigned DEB_T0_NS = 125;
	localparam int unsigned DEB_T1_NS = 6425;
	localparam int unsigned DEB_T2_NS = 2560000;
	localparam int unsigned DEB_C0 = (DEB_T0_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DEB_C1 = (DEB_T1_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DEB_C2 = (DEB_T2_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned MAX_RATE_MHZ = 10;
	localparam int unsigned MIN_SCLK_CYC = CLK_MHZ / MAX_RATE_MHZ;
	// Register byte offsets
	localparam logic [7:0] OFS_WAVE_DIR = 8'h00;
	localparam logic [7:0] OFS_WAVE_OUT = 8'h04;
	localparam logic [7:0] OFS_WAVE_IN = 8'h08;
	localparam logic [7:0] OFS_PFI_DIR = 8'h0c;
	localparam logic [7:0] OFS_PFI_OUT = 8'h10;
	localparam logic [7:0] OFS_PFI_IN = 8'h14;
	localparam logic [7:0] OFS_PFI_MODE = 8'h18;
	localparam logic [7:0] OFS_PFI_TSEL0 = 8'h1c;
	localparam logic [7:0] OFS_PFI_TSEL1 = 8'h20;
	localparam logic [7:0] OFS_DEB_SEL = 8'h24;
	localparam logic [7:0] OFS_WAVE_CTRL = 8'h28;
	localparam logic [7:0] OFS_GEN_DATA = 8'h2c;
	localparam logic [7:0] OFS_ACQ_DATA = 8'h30;
	localparam logic [7:0] OFS_FIFO_STAT = 8'h34;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h38;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h3c;
	localparam logic [7:0] OFS_DMA_ASSIGN = 8'h40;
	// Wave control field positions
	localparam int unsigned CTRL_GEN_EN = 0;
	localparam int unsigned CTRL_ACQ_EN = 1;
	localparam int unsigned CTRL_REGEN = 2;
	localparam int unsigned CTRL_SRC_LSB = 4;
	localparam int unsigned CTRL_SRC_W = 5;
	// Interrupt status bits
	localparam int unsigned IRQ_GEN_UNDER = 0;
	localparam int unsigned IRQ_ACQ_OVER = 1;
	localparam int unsigned IRQ_ACQ_DATA = 2;
	localparam int unsigned IRQ_N = 3;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_DATA = 32'hdead_0bad;

	typedef enum logic [1:0] {
		PFI_STATIC_IN = 2'b00,
		PFI_STATIC_OUT = 2'b01,
		PFI_TIMING_IN = 2'b10,
		PFI_TIMING_OUT = 2'b11
	} pfi_mode_e;

	typedef enum logic [1:0] {
		DMA_AI = 2'b00,
		DMA_DI = 2'b01,
		DMA_DO = 2'b10,
		DMA_CTR = 2'b11
	} dma_use_e;

	typedef struct packed {
		logic gen_req;
		logic acq_req;
	} dma_req_s;
endpackage : dio_pkg

// ---- rtl/sample_fifo.sv ----
// Sample FIFO memory with registered read data and rewind for regeneration
`timescale 1ns/1ns
module sample_fifo (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic flush,
	input wire logic rewind,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	output logic full,
	output logic empty,
	output logic [dio_pkg::FIFO_AW-1:0] count
);
	logic [7:0] mem [0:dio_pkg::FIFO_DEPTH-1];
	logic [dio_pkg::FIFO_AW-1:0] wp_reg;
	logic [dio_pkg::FIFO_AW-1:0] rp_reg;
	logic [dio_pkg::FIFO_AW-1:0] cnt_reg;
	logic [dio_pkg::FIFO_AW-1:0] last_wp_reg;
	wire do_wr = wr_en && !full;
	wire do_rd = rd_en && !empty;
	wire [dio_pkg::FIFO_AW-1:0] top = dio_pkg::FIFO_AW'(dio_pkg::FIFO_DEPTH - 1);
	wire [dio_pkg::FIFO_AW-1:0] wp_inc = (wp_reg == top) ? '0 : wp_reg + 1'b1;
	wire [dio_pkg::FIFO_AW-1:0] rp_inc = (rp_reg == top) ? '0 : rp_reg + 1'b1;

	assign full = (cnt_reg == dio_pkg::FIFO_AW'(dio_pkg::FIFO_DEPTH));
	assign empty = (cnt_reg == '0);
	assign count = cnt_reg;

	always_ff @(posedge core_clk) begin
		if (do_wr)
			mem[wp_reg] <= wr_data;
		if (do_rd)
			rd_data <= mem[rp_reg];
	end

	// Rewind replays everything written since the last flush, as long as fewer than 2047 samples were written
	always_ff @(posedge core_clk) begin
		if (reset || flush) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
			last_wp_reg <= '0;
		end else if (rewind) begin
			rp_reg <= '0;
			cnt_reg <= last_wp_reg;
		end else begin
			if (do_wr) begin
				wp_reg <= wp_inc;
				last_wp_reg <= wp_inc;
			end
			if (do_rd)
				rp_reg <= rp_inc;
			cnt_reg <= cnt_reg + (do_wr ? 1'b1 : 1'b0) - (do_rd ? 1'b1 : 1'b0);
		end
	end
endmodule : sample_fifo

// ---- rtl/waveform_digital_io_port.sv ----
// Digital I/O port: waveform port, function lines, debounce, sample FIFOs, APB registers, interrupt
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ns
module waveform_digital_io_port (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] waveform_port_lines_in,
	output logic [7:0] waveform_port_lines_out,
	output logic [7:0] waveform_port_lines_oe_n,
	input wire logic [15:0] programmable_function_lines_in,
	output logic [15:0] programmable_function_lines_out,
	output logic [15:0] programmable_function_lines_oe_n,
	input wire logic [7:0] system_trigger_bus,
	input wire logic [7:0] internal_timing,
	output logic [15:0] timing_in_pulse,
	output logic [1:0] dma_req,
	output logic [11:0] dma_assign,
	output logic irq
);
	//////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [23:0] pin_s1_reg;
	logic [23:0] pin_s2_reg;
	logic [7:0] trig_s1_reg;
	logic [7:0] trig_s2_reg;
	always_ff @(posedge core_clk) begin
		pin_s1_reg <= {programmable_function_lines_in, waveform_port_lines_in};
		pin_s2_reg <= pin_s1_reg;
		trig_s1_reg <= system_trigger_bus;
		trig_s2_reg <= trig_s1_reg;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] wave_dir_reg;
	logic [7:0] wave_out_reg;
	logic [15:0] pfi_dir_reg;
	logic [15:0] pfi_out_reg;
	logic [31:0] pfi_mode_reg;
	logic [31:0] tsel0_reg;
	logic [31:0] tsel1_reg;
	logic [31:0] deb_sel_reg;
	logic [8:0] ctrl_reg;
	logic [11:0] dma_asg_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;

	logic rd_pend_reg;
	logic acq_miss_reg;
	wire setup = psel && !penable;
	wire access = psel && penable && pready;
	wire wr = access && pwrite;
	// Pop at the setup edge so the registered RAM output is fresh one cycle later
	wire rd_acq = setup && !pwrite && (paddr == dio_pkg::OFS_ACQ_DATA) && !rd_pend_reg;
	wire wr_gen = wr && (paddr == dio_pkg::OFS_GEN_DATA);
	wire wr_ctrl = wr && (paddr == dio_pkg::OFS_WAVE_CTRL);
	wire gen_en = ctrl_reg[dio_pkg::CTRL_GEN_EN];
	wire acq_en = ctrl_reg[dio_pkg::CTRL_ACQ_EN];
	wire regen = ctrl_reg[dio_pkg::CTRL_REGEN];
	wire [4:0] sclk_src = ctrl_reg[dio_pkg::CTRL_SRC_LSB +: dio_pkg::CTRL_SRC_W];

	//////////////////////////////////////////////////////////////////////////////
	// Debounce filters, one per input line
	logic [23:0] filt;
	// Waveform lines get zero selects and so stay unfiltered
	wire [47:0] deb_all = {deb_sel_reg, 16'h0000};
	genvar gi;
	generate
		for (gi = 0; gi < 24; gi++) begin : g_deb
			logic [17:0] cnt_reg;
			logic state_reg;
			wire [1:0] sel = deb_all[2*gi +: 2];
			wire [17:0] lim = (sel == 2'd1) ? 18'(dio_pkg::DEB_C0) :
				(sel == 2'd2) ? 18'(dio_pkg::DEB_C1) : 18'(dio_pkg::DEB_C2);
			always_ff @(posedge core_clk) begin
				if (reset) begin
					cnt_reg <= '0;
					state_reg <= 1'b0;
				end else if (sel == 2'd0 || pin_s2_reg[gi] == state_reg) begin
					cnt_reg <= '0;
					state_reg <= pin_s2_reg[gi];
				end else if (cnt_reg + 18'd1 >= lim) begin
					cnt_reg <= '0;
					state_reg <= pin_s2_reg[gi];
				end else begin
					cnt_reg <= cnt_reg + 18'd1;
				end
			end
			assign filt[gi] = state_reg;
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////////
	// Sample clock selection and edge detection
	wire [31:0] sclk_pool = {internal_timing, trig_s2_reg, filt[23:8]};
	wire sclk_lvl = sclk_pool[sclk_src];
	logic sclk_d_reg;
	logic [15:0] filt_d_reg;
	always_ff @(posedge core_clk) begin
		sclk_d_reg <= sclk_lvl;
		filt_d_reg <= filt[23:8];
	end
	wire sclk_edge = sclk_lvl && !sclk_d_reg;

	//////////////////////////////////////////////////////////////////////////////
	// Sample FIFOs
	wire gen_full, gen_empty, acq_full, acq_empty;
	wire [7:0] gen_q, acq_q;
	wire [dio_pkg::FIFO_AW-1:0] gen_cnt;
	wire gen_pop = gen_en && sclk_edge;
	// Rewind while taking the last sample, so the next edge replays the first one
	wire gen_rewind = gen_pop && regen && (gen_cnt == dio_pkg::FIFO_AW'(1));
	wire acq_push = acq_en && sclk_edge && (wave_dir_reg != 8'hff);
	sample_fifo u_gen (
		.core_clk(core_clk),
		.reset(reset),
		.flush(wr_ctrl && !pwdata[dio_pkg::CTRL_GEN_EN]),
		.rewind(gen_rewind),
		.wr_en(wr_gen),
		.wr_data(pwdata[7:0]),
		.rd_en(gen_pop),
		.rd_data(gen_q),
		.full(gen_full),
		.empty(gen_empty),
		.count(gen_cnt)
	);
	sample_fifo u_acq (
		.core_clk(core_clk),
		.reset(reset),
		.flush(wr_ctrl && !pwdata[dio_pkg::CTRL_ACQ_EN]),
		.rewind(1'b0),
		.wr_en(acq_push),
		.wr_data(filt[7:0]),
		.rd_en(rd_acq),
		.rd_data(acq_q),
		.full(acq_full),
		.empty(acq_empty),
		.count()
	);
	logic gen_pop_d_reg;
	always_ff @(posedge core_clk) begin
		gen_pop_d_reg <= gen_pop && !gen_empty;
	end

	wire under_ev = gen_pop && gen_empty && !regen;
	wire over_ev = acq_push && acq_full;
	wire [2:0] ev = {!acq_empty, over_ev, under_ev};

	//////////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wave_dir_reg <= '0;
			pfi_dir_reg <= '0;
			wave_out_reg <= '0;
			pfi_out_reg <= '0;
			pfi_mode_reg <= dio_pkg::RST_ZERO;
			tsel0_reg <= dio_pkg::RST_ZERO;
			tsel1_reg <= dio_pkg::RST_ZERO;
			deb_sel_reg <= dio_pkg::RST_ZERO;
			ctrl_reg <= '0;
			dma_asg_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			if (wr && paddr == dio_pkg::OFS_WAVE_DIR)
				wave_dir_reg <= pwdata[7:0];
			if (wr && paddr == dio_pkg::OFS_WAVE_OUT)
				wave_out_reg <= pwdata[7:0];
			else if (gen_pop_d_reg)
				wave_out_reg <= gen_q;
			if (wr && paddr == dio_pkg::OFS_PFI_DIR)
				pfi_dir_reg <= pwdata[15:0];
			if (wr && paddr == dio_pkg::OFS_PFI_OUT)
				pfi_out_reg <= pwdata[15:0];
			if (wr && paddr == dio_pkg::OFS_PFI_MODE)
				pfi_mode_reg <= pwdata;
			if (wr && paddr == dio_pkg::OFS_PFI_TSEL0)
				tsel0_reg <= pwdata;
			if (wr && paddr == dio_pkg::OFS_PFI_TSEL1)
				tsel1_reg <= pwdata;
			if (wr && paddr == dio_pkg::OFS_DEB_SEL)
				deb_sel_reg <= pwdata;
			if (wr_ctrl)
				ctrl_reg <= pwdata[8:0];
			if (wr && paddr == dio_pkg::OFS_DMA_ASSIGN)
				dma_asg_reg <= pwdata[11:0];
			if (wr && paddr == dio_pkg::OFS_IRQ_MASK)
				irq_mask_reg <= pwdata[2:0];
		end
	end

	// Set wins over write-one-to-clear
	wire [2:0] w1c = (wr && paddr == dio_pkg::OFS_IRQ_STAT) ? pwdata[2:0] : 3'h0;
	always_ff @(posedge core_clk) begin
		if (reset)
			irq_stat_reg <= '0;
		else
			irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Function line output selection
	wire [7:0] tsrc_pool = {internal_timing[3:0], sclk_lvl, gen_pop_d_reg, acq_push, gen_empty};
	logic [15:0] pfi_drv;
	logic [15:0] pfi_oe;
	wire [63:0] tsel_all = {tsel1_reg, tsel0_reg};
	generate
		for (gi = 0; gi < 16; gi++) begin : g_pfi
			wire [1:0] mode = pfi_mode_reg[2*gi +: 2];
			wire [3:0] ts = tsel_all[4*gi +: 4];
			assign pfi_drv[gi] = (mode == dio_pkg::PFI_TIMING_OUT) ? tsrc_pool[ts[2:0]] : pfi_out_reg[gi];
			assign pfi_oe[gi] = pfi_dir_reg[gi] && (mode == dio_pkg::PFI_STATIC_OUT || mode == dio_pkg::PFI_TIMING_OUT);
		end
	endgenerate
	wire [15:0] tin_mask;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_tin
			assign tin_mask[gi] = (pfi_mode_reg[2*gi +: 2] == dio_pkg::PFI_TIMING_IN);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////////
	// Read mux and APB answer
	wire [31:0] rmux =
		(paddr == dio_pkg::OFS_WAVE_DIR) ? {24'h0, wave_dir_reg} :
		(paddr == dio_pkg::OFS_WAVE_OUT) ? {24'h0, wave_out_reg} :
		(paddr == dio_pkg::OFS_WAVE_IN) ? {24'h0, filt[7:0]} :
		(paddr == dio_pkg::OFS_PFI_DIR) ? {16'h0, pfi_dir_reg} :
		(paddr == dio_pkg::OFS_PFI_OUT) ? {16'h0, pfi_out_reg} :
		(paddr == dio_pkg::OFS_PFI_IN) ? {16'h0, filt[23:8]} :
		(paddr == dio_pkg::OFS_PFI_MODE) ? pfi_mode_reg :
		(paddr == dio_pkg::OFS_PFI_TSEL0) ? tsel0_reg :
		(paddr == dio_pkg::OFS_PFI_TSEL1) ? tsel1_reg :
		(paddr == dio_pkg::OFS_DEB_SEL) ? deb_sel_reg :
		(paddr == dio_pkg::OFS_WAVE_CTRL) ? {23'h0, ctrl_reg} :
		(paddr == dio_pkg::OFS_FIFO_STAT) ? {28'h0, acq_full, acq_empty, gen_full, gen_empty} :
		(paddr == dio_pkg::OFS_IRQ_STAT) ? {29'h0, irq_stat_reg} :
		(paddr == dio_pkg::OFS_IRQ_MASK) ? {29'h0, irq_mask_reg} :
		(paddr == dio_pkg::OFS_DMA_ASSIGN) ? {20'h0, dma_asg_reg} :
		(paddr == dio_pkg::OFS_GEN_DATA) ? 32'h0000_0000 :
		dio_pkg::UNMAPPED_DATA;
	wire mapped = (paddr[1:0] == 2'b00) && (paddr <= dio_pkg::OFS_DMA_ASSIGN) && (paddr != dio_pkg::OFS_ACQ_DATA);

	// Acquisition data take one extra cycle: RAM output is registered
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
			rd_pend_reg <= 1'b0;
			acq_miss_reg <= 1'b0;
		end else if (rd_acq) begin
			rd_pend_reg <= 1'b1;
			acq_miss_reg <= acq_empty;
			pready <= 1'b0;
		end else if (rd_pend_reg && !pready) begin
			pready <= 1'b1;
			prdata <= {24'h0, acq_q};
			pslverr <= acq_miss_reg;
		end else if (setup) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0 : rmux;
			pslverr <= !mapped && !(paddr == dio_pkg::OFS_ACQ_DATA);
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			if (access)
				rd_pend_reg <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			waveform_port_lines_out <= '0;
			waveform_port_lines_oe_n <= 8'hff;
			programmable_function_lines_out <= '0;
			programmable_function_lines_oe_n <= 16'hffff;
			timing_in_pulse <= '0;
			dma_req <= '0;
			dma_assign <= '0;
			irq <= 1'b0;
		end else begin
			waveform_port_lines_out <= wave_out_reg;
			waveform_port_lines_oe_n <= ~wave_dir_reg;
			programmable_function_lines_out <= pfi_drv;
			programmable_function_lines_oe_n <= ~pfi_oe;
			timing_in_pulse <= filt[23:8] & ~filt_d_reg & tin_mask;
			dma_req <= {gen_en && !regen && !gen_full, acq_en && !acq_empty};
			dma_assign <= dma_asg_reg;
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Checks
	reset_dir_a: assert property (@(posedge core_clk) $past(reset) |-> (waveform_port_lines_oe_n == 8'hff) && (programmable_function_lines_oe_n == 16'hffff)) else $error("lines not inputs after reset");
	under_flag_a: assert property (@(posedge core_clk) disable iff (reset) under_ev |=> irq_stat_reg[dio_pkg::IRQ_GEN_UNDER]) else $error("underrun not flagged");
	over_flag_a: assert property (@(posedge core_clk) disable iff (reset) over_ev |=> irq_stat_reg[dio_pkg::IRQ_ACQ_OVER]) else $error("overrun not flagged");
	flag_hold_a: assert property (@(posedge core_clk) disable iff (reset) irq_stat_reg[0] && !w1c[0] |=> irq_stat_reg[0]) else $error("error flag lost");
	dir_follow_a: assert property (@(posedge core_clk) disable iff (reset) wr && paddr == dio_pkg::OFS_PFI_DIR && pfi_mode_reg == 32'h5555_5555 |=> ##1 programmable_function_lines_oe_n == ~$past(pwdata[15:0], 2)) else $error("direction not applied");
	wave_dir_a: assert property (@(posedge core_clk) disable iff (reset) wr && paddr == dio_pkg::OFS_WAVE_DIR |=> ##1 waveform_port_lines_oe_n == ~$past(pwdata[7:0], 2)) else $error("port direction not applied");
	deb_off_a: assert property (@(posedge core_clk) disable iff (reset) deb_sel_reg[1:0] == 2'd0 && $stable(deb_sel_reg) |=> filt[8] == $past(pin_s2_reg[8])) else $error("unfiltered input lags");
	irq_level_a: assert property (@(posedge core_clk) disable iff (reset) (irq_stat_reg & irq_mask_reg) == 3'h0 |=> !irq) else $error("irq with nothing pending");
	acq_count_a: assert property (@(posedge core_clk) disable iff (reset) acq_push && !acq_full && !rd_acq |=> !acq_empty) else $error("sample not stored");
endmodule : waveform_digital_io_port

// ---- testbench/line_partner.sv ----
// External line model: pin drivers with pull-downs and a trigger-line sample clock
`timescale 1ns/1ns
module line_partner (
	input wire logic core_clk,
	input wire logic [7:0] wave_out,
	input wire logic [7:0] wave_oe_n,
	input wire logic [15:0] pfi_out,
	input wire logic [15:0] pfi_oe_n,
	input wire logic [7:0] wave_drive,
	input wire logic [7:0] wave_drive_en,
	input wire logic [15:0] pfi_drive,
	input wire logic [15:0] pfi_drive_en,
	output logic [7:0] wave_pins,
	output logic [15:0] pfi_pins,
	output logic [7:0] trig
);
	////////////////////////////////////////////////////////////////////////////////
	// A line nobody drives falls to the pull-down level
	assign wave_pins = (~wave_oe_n & wave_out) | (wave_oe_n & wave_drive_en & wave_drive);
	assign pfi_pins = (~pfi_oe_n & pfi_out) | (pfi_oe_n & pfi_drive_en & pfi_drive);
	initial trig = 8'h00;
	////////////////////////////////////////////////////////////////////////////////
	// Sample clock at the 10 MHz ceiling on trigger line 0, still between bursts
	task automatic sample_clock(input int n);
		repeat (n) begin
			@(posedge core_clk);
			trig[0] <= 1'b1;
			repeat (5) @(posedge core_clk);
			trig[0] <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
	endtask : sample_clock
endmodule : line_partner

// ---- testbench/waveform_digital_io_port_test.sv ----
// Self-checking bench of the digital I/O port
`timescale 1ns/1ns
module waveform_digital_io_port_test;
	logic core_clk, reset, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr, wave_in, wave_out, wave_oe_n, trig, it_val, wdrv, wen;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pfi_in, pfi_out, pfi_oe_n, tin_pulse, pdrv, pen;
	logic [1:0] dma_req;
	logic [11:0] dma_assign;
	int n_fail = 0;
	int n_checks = 0;
	int cycles = 0;
	int pulses = 0;
	int pulses3 = 0;

	waveform_digital_io_port DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.waveform_port_lines_in(wave_in), .waveform_port_lines_out(wave_out), .waveform_port_lines_oe_n(wave_oe_n),
		.programmable_function_lines_in(pfi_in), .programmable_function_lines_out(pfi_out),
		.programmable_function_lines_oe_n(pfi_oe_n), .system_trigger_bus(trig), .internal_timing(it_val),
		.timing_in_pulse(tin_pulse), .dma_req(dma_req), .dma_assign(dma_assign), .irq(irq));

	line_partner P (.core_clk(core_clk), .wave_out(wave_out), .wave_oe_n(wave_oe_n), .pfi_out(pfi_out),
		.pfi_oe_n(pfi_oe_n), .wave_drive(wdrv), .wave_drive_en(wen), .pfi_drive(pdrv), .pfi_drive_en(pen),
		.wave_pins(wave_in), .pfi_pins(pfi_in), .trig(trig));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Timeout and timing-input pulse counters
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (tin_pulse[1] === 1'b1) pulses <= pulses + 1;
		if (tin_pulse[3] === 1'b1) pulses3 <= pulses3 + 1;
		if (cycles == 40000) begin
			n_fail++;
			$display("[ERR] %0t run did not finish", $time);
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge core_clk);
		end
		if (n == 16) begin
			n_fail++;
			$display("[ERR] %0t no bus answer", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd & m, exp, what);
	endtask : rdchk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		it_val = 8'h00;
		wdrv = 8'h00;
		wen = 8'h00;
		pdrv = 16'h0000;
		pen = 16'h0000;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		chk(32'(wave_oe_n), 32'h0000_00ff, "port released");
		chk(32'(pfi_oe_n), 32'h0000_ffff, "function lines released");
		chk(32'(irq), 32'h0000_0000, "irq idle");
		rdchk(dio_pkg::OFS_WAVE_DIR, 32'h0000_00ff, 32'h0000_0000, "direction reset");
		$display("test reset done");

		wr(dio_pkg::OFS_WAVE_DIR, 32'h0000_000f);
		wr(dio_pkg::OFS_WAVE_OUT, 32'h0000_00a5);
		wdrv <= 8'h90;
		wen <= 8'hf0;
		cyc(4);
		chk(32'(wave_oe_n), 32'h0000_00f0, "port direction");
		chk(32'(wave_out[3:0]), 32'h0000_0005, "port drive");
		rdchk(dio_pkg::OFS_WAVE_IN, 32'h0000_00ff, 32'h0000_0095, "port readback");
		wr(dio_pkg::OFS_PFI_MODE, 32'h4000_0001);
		wr(dio_pkg::OFS_PFI_DIR, 32'h0000_8003);
		wr(dio_pkg::OFS_PFI_OUT, 32'h0000_8000);
		pdrv <= 16'h0002;
		pen <= 16'h0002;
		cyc(4);
		chk(32'(pfi_oe_n), 32'h0000_7ffe, "function line drive enables");
		chk(32'(pfi_out & 16'h8001), 32'h0000_8000, "function line levels");
		rdchk(dio_pkg::OFS_PFI_IN, 32'h0000_8003, 32'h0000_8002, "function line readback");
		apb(1'b0, 8'h44, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001, "unmapped error");
		chk(rd, dio_pkg::UNMAPPED_DATA, "unmapped data");
		wr(dio_pkg::OFS_DMA_ASSIGN, 32'h0000_0e4b);
		cyc(2);
		chk(32'(dma_assign), 32'h0000_0e4b, "channel uses");
		$display("test static lines done");

		wr(dio_pkg::OFS_WAVE_DIR, 32'h0000_00ff);
		wr(dio_pkg::OFS_WAVE_CTRL, 32'h0000_0101);
		wr(dio_pkg::OFS_GEN_DATA, 32'h0000_0011);
		wr(dio_pkg::OFS_GEN_DATA, 32'h0000_0022);
		cyc(2);
		chk(32'(dma_req[1]), 32'h0000_0001, "generation wants data");
		P.sample_clock(1);
		cyc(6);
		chk(32'(wave_out), 32'h0000_0011, "first sample");
		P.sample_clock(1);
		cyc(6);
		chk(32'(wave_out), 32'h0000_0022, "second sample");
		P.sample_clock(1);
		cyc(6);
		rdchk(dio_pkg::OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001, "underrun");
		chk(32'(irq), 32'h0000_0000, "masked irq");
		wr(dio_pkg::OFS_IRQ_MASK, 32'h0000_0001);
		cyc(3);
		chk(32'(irq), 32'h0000_0001, "irq raised");
		wr(dio_pkg::OFS_IRQ_STAT, 32'h0000_0001);
		cyc(3);
		chk(32'(irq), 32'h0000_0000, "irq cleared");
		wr(dio_pkg::OFS_WAVE_CTRL, 32'h0000_0000);
		wr(dio_pkg::OFS_WAVE_CTRL, 32'h0000_0105);
		wr(dio_pkg::OFS_GEN_DATA, 32'h0000_0033);
		wr(dio_pkg::OFS_GEN_DATA, 32'h0000_0044);
		P.sample_clock(3);
		cyc(6);
		chk(32'(wave_out), 32'h0000_0033, "regenerated sample");
		rdchk(dio_pkg::OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0000, "no underrun in regeneration");
		$display("test generation done");

		wr(dio_pkg::OFS_WAVE_CTRL, 32'h0000_0000);
		wr(dio_pkg::OFS_WAVE_DIR, 32'h0000_0000);
		wdrv <= 8'h3c;
		wen <= 8'hff;
		wr(dio_pkg::OFS_WAVE_CTRL, 32'h0000_0102);
		P.sample_clock(1);
		cyc(6);
		chk(32'(dma_req[0]), 32'h0000_0001, "acquisition has data");
		rdchk(dio_pkg::OFS_ACQ_DATA, 32'h0000_00ff, 32'h0000_003c, "captured sample");
		apb(1'b0, dio_pkg::OFS_ACQ_DATA, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001, "read of empty acquisition");
		P.sample_clock(2047);
		cyc(6);
		rdchk(dio_pkg::OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0000, "no overrun at depth");
		rdchk(dio_pkg::OFS_FIFO_STAT, 32'h0000_0008, 32'h0000_0008, "acquisition full");
		P.sample_clock(1);
		cyc(6);
		rdchk(dio_pkg::OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002, "overrun");
		wr(dio_pkg::OFS_WAVE_CTRL, 32'h0000_0000);
		rdchk(dio_pkg::OFS_FIFO_STAT, 32'h0000_0004, 32'h0000_0004, "flushed");
		$display("test acquisition done");

		pdrv <= 16'h0000;
		pen <= 16'h000a;
		wr(dio_pkg::OFS_PFI_MODE, 32'h0000_0088);
		wr(dio_pkg::OFS_DEB_SEL, 32'h0000_0004);
		cyc(30);
		pulses <= 0;
		pulses3 <= 0;
		pdrv <= 16'h000a;
		cyc(5);
		pdrv <= 16'h0000;
		cyc(30);
		chk(32'(pulses), 32'h0000_0000, "short high filtered");
		chk(32'(pulses3), 32'h0000_0001, "unfiltered line");
		pdrv <= 16'h0002;
		cyc(40);
		chk(32'(pulses), 32'h0000_0001, "long high passes");
		pdrv <= 16'h0000;
		cyc(5);
		pdrv <= 16'h0002;
		cyc(40);
		chk(32'(pulses), 32'h0000_0001, "short low filtered");
		$display("test debounce done");

		wr(dio_pkg::OFS_PFI_MODE, 32'h0000_0030);
		wr(dio_pkg::OFS_PFI_DIR, 32'h0000_0004);
		wr(dio_pkg::OFS_PFI_TSEL0, 32'h0000_0400);
		it_val <= 8'h01;
		cyc(4);
		chk(32'(pfi_out[2]), 32'h0000_0001, "timing output high");
		chk(32'(pfi_oe_n[2]), 32'h0000_0000, "timing output drives");
		it_val <= 8'h00;
		cyc(4);
		chk(32'(pfi_out[2]), 32'h0000_0000, "timing output low");
		$display("test timing output done");
		test_done();
	end
endmodule : waveform_digital_io_port_test
